// ---- include/zone_pkg.sv ----
/*
 Shared constants and types of the paging panel zone selection logic.
 Assumes a 125 MHz system clock and an APB master with 32-bit data.
*/
package zone_pkg;

  localparam int ZONES = 16;
  localparam int GROUPS = 2;
  localparam int KEYS = 21;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 8;
  localparam int FLASH_W = 8;

  // Timing: period figures in ms, counts derived from the clock rate
  localparam int CLK_HZ = 125_000_000;
  localparam int BLINK_HALF_MS = 250;
  localparam int CHIME_MS = 2000;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int CHIME_CYC = CLK_HZ / 1000 * CHIME_MS;
  localparam int FLASH_HALVES = 12;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZONE_EN = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_HOLD = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INTR = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_GROUP1 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_GROUP2 = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_SEL = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_KEYEV = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;

  // Control register fields
  localparam int CTRL_ONLINE = 0;
  localparam int CTRL_FWUPD = 1;
  localparam int CTRL_CHIME = 2;
  localparam int CTRL_GRP_ON = 4;
  localparam int CTRL_GRP_SET = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // Key vector positions (also key event register bits)
  localparam int KEY_GRP = 16;
  localparam int KEY_ALL = 18;
  localparam int KEY_CLR = 19;
  localparam int KEY_PAGE = 20;

  // Status register fields
  localparam int STAT_PAGE_KEY = 0;
  localparam int STAT_VOICE = 1;
  localparam int STAT_CHIME = 2;
  localparam int STAT_ONLINE = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic red;
    logic green;
  } bicolour_t;

  typedef enum logic [2:0] {
    ST_OFFLINE,
    ST_IDLE,
    ST_CHIME,
    ST_TALK,
    ST_FWUPD
  } page_st_t;

endpackage : zone_pkg

// ---- hdl/key_sync.sv ----
/*
 Key input synchroniser: three flops per key, level and press pulse.
 Assumes raw key inputs are asynchronous and high while pressed.
*/
`timescale 1ns/1ps
module key_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Raw keys
  input wire logic [W-1:0] i_raw,
  // Clean keys
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_press
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
    logic [W-1:0] press;
  } sync_t;

  sync_t st_ff;
  sync_t nxt_st;
  logic [W-1:0] agree;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = i_raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Only the later stages vote, the first stays metastability buffer
    agree = st_ff.s2 ~^ st_ff.s3;
    nxt_st.level = (agree & st_ff.s3) | (~agree & st_ff.level);
    nxt_st.press = nxt_st.level & ~st_ff.level;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_level = st_ff.level;
  assign o_press = st_ff.press;

endmodule : key_sync

// ---- hdl/zone_cell.sv ----
/*
 One zone: selection, interruption latch, refusal flash and LED colour.
 Assumes key strobes are clean one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module zone_cell
  import zone_pkg::*;
#(
  parameter int FLASH_N = FLASH_HALVES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Controller status
  input wire logic i_enabled,
  input wire logic i_hold,
  input wire logic i_intr_set,
  // Key strobes
  input wire logic i_key_press,
  input wire logic i_all,
  input wire logic i_clr,
  input wire logic i_group,
  input wire logic i_freeze,
  // Blink timing
  input wire logic i_blink,
  input wire logic i_blink_tick,
  // Outputs
  output logic o_sel,
  output logic o_intr,
  output zone_pkg::bicolour_t o_led
);

  typedef struct packed {
    logic sel;
    logic intr;
    logic [FLASH_W-1:0] flash;
  } cell_t;

  cell_t st_ff;
  cell_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.flash != '0 && i_blink_tick)
      nxt_st.flash = st_ff.flash - 8'h01;
    if (!i_freeze)
    begin
      if (i_key_press && i_enabled)
      begin
        // A pending warning is acknowledged, zone ends selected
        nxt_st.sel = st_ff.intr ? 1'b1 : ~st_ff.sel;
        nxt_st.intr = 1'b0;
      end
      else if (i_key_press)
        nxt_st.flash = FLASH_W'(FLASH_N);
      if (i_group && i_enabled)
        nxt_st.sel = 1'b1;
      if (i_all)
      begin
        nxt_st.sel = nxt_st.sel | i_enabled;
        nxt_st.intr = 1'b0;
      end
      if (i_clr)
      begin
        nxt_st.sel = 1'b0;
        nxt_st.intr = 1'b0;
      end
    end
    if (!i_enabled)
      nxt_st.sel = 1'b0;
    // New interruption beats a same-cycle acknowledge
    if (i_intr_set)
      nxt_st.intr = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  always_comb
  begin
    o_led = '0;
    if (st_ff.flash != '0)
      o_led.green = i_blink;
    else if (st_ff.intr)
      o_led = '{red: 1'b1, green: 1'b1};
    else if (i_hold)
    begin
      o_led.red = st_ff.sel ? i_blink : 1'b1;
      o_led.green = st_ff.sel & i_blink;
    end
    else
      o_led.green = st_ff.sel;
  end

  assign o_sel = st_ff.sel;
  assign o_intr = st_ff.intr;

endmodule : zone_cell

// ---- hdl/paging_panel.sv ----
/*
 Paging console front panel: keys, zone selection, LEDs, paging control,
 and an APB register file through which the zone controller talks.
 Assumes keys are active high pins and the controller side software
 mirrors enabled zones, holds and interruptions into the registers.
*/
// Design decisions made here: register access over APB and the register offsets.
// How it works
// - Zone key press toggles its selection
// - Non-enabled zones cannot be selected
// - Non-enabled zone key flashes green briefly
// - All key selects every enabled zone
// - Clear key deselects every zone
// - Voice active only while paging key held
// - Chime starts on paging press when programmed
// - Display dashes for non-enabled zones
// - Twenty-one user keys
// - Zone LED off free, green selected
// - Held zone: red unselected, flashing orange selected
// - Interrupted broadcast latches steady orange
// - Zone, all or clear key clears orange
// - Paging LED orange during chime, then green
// - Paging LED green while voice sent
// - Paging LED red when not operational
// - Firmware update: orange LED, upgrade message
// - All/clear LEDs green while pressed
// - Group keys select groups; LED shows enable
// - Unassigned group key LED flashes green
// - Selection frozen while paging key held
// - Released hold restores dark or green
`timescale 1ns/1ps
module paging_panel
  import zone_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = BLINK_HALF_CYC,
  parameter int CHIME_CYCLES = CHIME_CYC,
  parameter int FLASH_N = FLASH_HALVES
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // APB slave
  input zone_pkg::apb_req_t I_APB,
  output logic [zone_pkg::DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // User keys
  input wire logic [zone_pkg::ZONES-1:0] I_ZONE_KEY,
  input wire logic I_GROUP_KEY_ONE,
  input wire logic I_GROUP_KEY_TWO,
  input wire logic I_ALL_KEY,
  input wire logic I_CLEAR_SELECTION_KEY,
  input wire logic I_PAGE_KEY,
  // LEDs
  output zone_pkg::bicolour_t [zone_pkg::ZONES-1:0] O_ZONE_LED,
  output zone_pkg::bicolour_t O_PAGE_LED,
  output logic O_ALL_LED,
  output logic O_CLEAR_LED,
  output logic [zone_pkg::GROUPS-1:0] O_GROUP_LED,
  // Audio path and display
  output logic O_VOICE_ON,
  output logic O_CHIME_START,
  output logic [zone_pkg::ZONES-1:0] O_DISP_DASH,
  output logic O_DISP_FW_MSG
);

  import zone_pkg::*;

  if (BLINK_HALF_CYCLES < 1 || CHIME_CYCLES < 1 || FLASH_N < 1 ||
      FLASH_N > 255)
  begin : g_bad_param
    $error("paging_panel: timing parameter out of range");
  end

  // Key vector layout follows the pin concatenation below
  if (KEYS != ZONES + GROUPS + 3 || KEY_GRP != ZONES ||
      KEY_ALL != KEY_GRP + GROUPS || KEY_CLR != KEY_ALL + 1 ||
      KEY_PAGE != KEYS - 1)
  begin : g_bad_keys
    $error("paging_panel: key vector layout inconsistent");
  end

  // Only two group mask registers exist
  if (GROUPS != 2)
  begin : g_bad_groups
    $error("paging_panel: group key count must be two");
  end

  // Every register field must fit one bus word
  if (ZONES > DATA_W || KEYS > DATA_W || CTRL_W > DATA_W ||
      CTRL_GRP_SET + GROUPS > CTRL_W || CTRL_GRP_ON + GROUPS > CTRL_W ||
      STAT_ONLINE >= DATA_W)
  begin : g_bad_fields
    $error("paging_panel: register field outside bus word");
  end

  // Decode compares whole addresses, so they must be word aligned
  if (((ADDR_CTRL | ADDR_ZONE_EN | ADDR_HOLD | ADDR_INTR | ADDR_GROUP1 |
        ADDR_GROUP2 | ADDR_SEL | ADDR_KEYEV | ADDR_STATUS) & 8'h03) != 8'h00)
  begin : g_bad_addr
    $error("paging_panel: register address not word aligned");
  end

  // Refusal flash length must fit the per-zone down counter
  if (FLASH_N >= 2 ** FLASH_W)
  begin : g_bad_flash
    $error("paging_panel: flash length exceeds counter width");
  end

  typedef struct packed {
    page_st_t page;
    logic [31:0] blink_cnt;
    logic blink;
    logic blink_tick;
    logic [31:0] chime_cnt;
    logic chime_start;
    logic [CTRL_W-1:0] ctrl;
    logic [ZONES-1:0] zone_en;
    logic [ZONES-1:0] hold;
    logic [ZONES-1:0] group1;
    logic [ZONES-1:0] group2;
    logic [ZONES-1:0] intr_set;
    logic [KEYS-1:0] keyev;
    logic [DATA_W-1:0] prdata;
  } panel_t;

  panel_t st_ff;
  panel_t nxt_st;

  logic [KEYS-1:0] key_raw;
  logic [KEYS-1:0] key_lvl;
  logic [KEYS-1:0] key_prs;
  logic [ZONES-1:0] sel;
  logic [ZONES-1:0] intr;
  logic [ZONES-1:0] grp_apply;
  logic [GROUPS-1:0] grp_on;
  logic [GROUPS-1:0] grp_set;
  logic [GROUPS-1:0] grp_go;
  logic freeze;
  logic online;
  logic fwupd;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic mapped;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] status;

  assign key_raw = {I_PAGE_KEY, I_CLEAR_SELECTION_KEY, I_ALL_KEY,
                    I_GROUP_KEY_TWO, I_GROUP_KEY_ONE, I_ZONE_KEY};

  key_sync #(
    .W(KEYS)
  ) u_keys (
    .i_clk(I_CLOCK),
    .i_nrst(I_NRST),
    .i_raw(key_raw),
    .o_level(key_lvl),
    .o_press(key_prs)
  );

  assign freeze = key_lvl[KEY_PAGE];
  assign online = st_ff.ctrl[CTRL_ONLINE];
  assign fwupd = st_ff.ctrl[CTRL_FWUPD];
  assign grp_on = st_ff.ctrl[CTRL_GRP_ON +: GROUPS];
  assign grp_set = st_ff.ctrl[CTRL_GRP_SET +: GROUPS];
  // Unassigned or switched-off group keys do nothing
  assign grp_go = key_prs[KEY_GRP +: GROUPS] & grp_set & grp_on;
  assign grp_apply = ({ZONES{grp_go[0]}} & st_ff.group1) |
                     ({ZONES{grp_go[1]}} & st_ff.group2);

  for (genvar z = 0; z < ZONES; z++)
  begin : g_zone
    zone_cell #(
      .FLASH_N(FLASH_N)
    ) u_cell (
      .i_clk(I_CLOCK),
      .i_nrst(I_NRST),
      .i_enabled(st_ff.zone_en[z]),
      .i_hold(st_ff.hold[z]),
      .i_intr_set(st_ff.intr_set[z]),
      .i_key_press(key_prs[z]),
      .i_all(key_prs[KEY_ALL]),
      .i_clr(key_prs[KEY_CLR]),
      .i_group(grp_apply[z]),
      .i_freeze(freeze),
      .i_blink(st_ff.blink),
      .i_blink_tick(st_ff.blink_tick),
      .o_sel(sel[z]),
      .o_intr(intr[z]),
      .o_led(O_ZONE_LED[z])
    );
  end

  // APB decode
  assign setup_ph = I_APB.psel & ~I_APB.penable;
  assign access_ph = I_APB.psel & I_APB.penable;
  assign wr_en = access_ph & I_APB.pwrite;

  always_comb
  begin
    status = '0;
    status[STAT_PAGE_KEY] = key_lvl[KEY_PAGE];
    status[STAT_VOICE] = O_VOICE_ON;
    status[STAT_CHIME] = (st_ff.page == ST_CHIME);
    status[STAT_ONLINE] = online;
  end

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = '0;
    case (I_APB.paddr)
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = st_ff.ctrl;
      ADDR_ZONE_EN: rd_mux[ZONES-1:0] = st_ff.zone_en;
      ADDR_HOLD: rd_mux[ZONES-1:0] = st_ff.hold;
      ADDR_INTR: rd_mux[ZONES-1:0] = intr;
      ADDR_GROUP1: rd_mux[ZONES-1:0] = st_ff.group1;
      ADDR_GROUP2: rd_mux[ZONES-1:0] = st_ff.group2;
      ADDR_SEL: rd_mux[ZONES-1:0] = sel;
      ADDR_KEYEV: rd_mux[KEYS-1:0] = st_ff.keyev;
      ADDR_STATUS: rd_mux = status;
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.chime_start = 1'b0;
    nxt_st.intr_set = '0;
    nxt_st.blink_tick = 1'b0;

    // Shared blink base for every flashing indication
    if (st_ff.blink_cnt >= 32'(BLINK_HALF_CYCLES - 1))
    begin
      nxt_st.blink_cnt = '0;
      nxt_st.blink = ~st_ff.blink;
      nxt_st.blink_tick = 1'b1;
    end
    else
      nxt_st.blink_cnt = st_ff.blink_cnt + 32'h1;

    // Read data captured in setup so it leaves a flop in access
    if (setup_ph)
      nxt_st.prdata = rd_mux;

    if (wr_en)
    begin
      case (I_APB.paddr)
        ADDR_CTRL: nxt_st.ctrl = I_APB.pwdata[CTRL_W-1:0];
        ADDR_ZONE_EN: nxt_st.zone_en = I_APB.pwdata[ZONES-1:0];
        ADDR_HOLD: nxt_st.hold = I_APB.pwdata[ZONES-1:0];
        ADDR_INTR: nxt_st.intr_set = I_APB.pwdata[ZONES-1:0];
        ADDR_GROUP1: nxt_st.group1 = I_APB.pwdata[ZONES-1:0];
        ADDR_GROUP2: nxt_st.group2 = I_APB.pwdata[ZONES-1:0];
        ADDR_KEYEV:
          nxt_st.keyev = st_ff.keyev & ~I_APB.pwdata[KEYS-1:0];
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    // New presses beat a same-cycle clear
    nxt_st.keyev = nxt_st.keyev | key_prs;

    case (st_ff.page)
      ST_OFFLINE:
        if (online)
          nxt_st.page = ST_IDLE;
      ST_IDLE:
        if (key_prs[KEY_PAGE])
        begin
          if (st_ff.ctrl[CTRL_CHIME])
          begin
            nxt_st.page = ST_CHIME;
            nxt_st.chime_cnt = '0;
            nxt_st.chime_start = 1'b1;
          end
          else
            nxt_st.page = ST_TALK;
        end
      ST_CHIME:
        if (!key_lvl[KEY_PAGE])
          nxt_st.page = ST_IDLE;
        else if (st_ff.chime_cnt >= 32'(CHIME_CYCLES - 1))
          nxt_st.page = ST_TALK;
        else
          nxt_st.chime_cnt = st_ff.chime_cnt + 32'h1;
      ST_TALK:
        if (!key_lvl[KEY_PAGE])
          nxt_st.page = ST_IDLE;
      ST_FWUPD:
        if (!fwupd)
          nxt_st.page = ST_OFFLINE;
      default:
        nxt_st.page = ST_OFFLINE;
    endcase
    // Update and loss of link override any paging in progress
    if (fwupd)
      nxt_st.page = ST_FWUPD;
    else if (!online)
      nxt_st.page = ST_OFFLINE;
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      st_ff <= '0;
      st_ff.page <= ST_OFFLINE;
      st_ff.ctrl <= CTRL_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // Bus answers in the first access cycle
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_ph & ~mapped;
  assign O_PRDATA = st_ff.prdata;

  assign O_VOICE_ON = (st_ff.page == ST_CHIME) ||
                      (st_ff.page == ST_TALK);
  assign O_CHIME_START = st_ff.chime_start;

  always_comb
  begin
    O_PAGE_LED = '0;
    case (st_ff.page)
      ST_OFFLINE: O_PAGE_LED.red = 1'b1;
      ST_CHIME: O_PAGE_LED = '{red: 1'b1, green: 1'b1};
      ST_TALK: O_PAGE_LED.green = 1'b1;
      ST_FWUPD: O_PAGE_LED = '{red: 1'b1, green: 1'b1};
      default: O_PAGE_LED = '0;
    endcase
  end

  assign O_ALL_LED = key_lvl[KEY_ALL];
  assign O_CLEAR_LED = key_lvl[KEY_CLR];
  assign O_GROUP_LED = (grp_set & grp_on) |
                       (~grp_set & {GROUPS{st_ff.blink}});

  assign O_DISP_DASH = ~st_ff.zone_en;
  assign O_DISP_FW_MSG = (st_ff.page == ST_FWUPD);

endmodule : paging_panel

// ---- test/paging_panel_properties.sv ----
/*
 Port checker for the paging panel.
 Assumes a bind onto paging_panel and keys held for many cycles.
*/
`timescale 1ns/1ps
module paging_panel_properties
  import zone_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // Bus
  input zone_pkg::apb_req_t I_APB,
  input wire logic O_PSLVERR,
  // Keys
  input wire logic I_ALL_KEY,
  input wire logic I_CLEAR_SELECTION_KEY,
  input wire logic I_PAGE_KEY,
  // Indicators
  input zone_pkg::bicolour_t O_PAGE_LED,
  input wire logic O_ALL_LED,
  input wire logic O_CLEAR_LED,
  input wire logic O_VOICE_ON,
  input wire logic O_CHIME_START,
  input wire logic O_DISP_FW_MSG
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);
  err_in_access_a: assert property (
    O_PSLVERR |-> I_APB.psel && I_APB.penable)
    else $error("slave error outside access phase");
  voice_needs_key_a: assert property (
    $rose(O_VOICE_ON) |-> I_PAGE_KEY)
    else $error("voice started without page key");
  voice_stops_a: assert property (
    $fell(I_PAGE_KEY) |-> ##[1:8] !O_VOICE_ON)
    else $error("voice kept after page key release");
  chime_orange_a: assert property (O_CHIME_START |-> ##[0:1]
    (O_PAGE_LED.red && O_PAGE_LED.green)) else $error("no orange in chime");
  chime_pulse_a: assert property (O_CHIME_START |=> !O_CHIME_START)
    else $error("chime start longer than one cycle");
  talk_green_a: assert property (O_VOICE_ON |-> O_PAGE_LED.green)
    else $error("page led not green while voice on");
  offline_quiet_a: assert property (
    (O_PAGE_LED.red && !O_PAGE_LED.green) |-> !O_VOICE_ON)
    else $error("voice while not operational");
  fw_orange_a: assert property (O_DISP_FW_MSG |-> O_PAGE_LED.red
    && O_PAGE_LED.green && !O_VOICE_ON) else $error("update indication wrong");
  all_led_a: assert property ($rose(O_ALL_LED) |-> $past(I_ALL_KEY))
    else $error("all led lit without key");
  clear_led_a: assert property ($fell(I_CLEAR_SELECTION_KEY)
    |-> ##[1:5] !O_CLEAR_LED) else $error("clear led stays lit");
  cover property (O_CHIME_START);
  cover property (O_DISP_FW_MSG);
  cover property (O_PSLVERR);
endmodule : paging_panel_properties

// ---- test/zone_ctrl_model.sv ----
/*
 Zone controller model: APB master that mirrors zone status.
 Assumes the caller enters xfer just after a rising edge.
*/
`timescale 1ns/1ps
module zone_ctrl_model
  import zone_pkg::*;
(
  // Bus
  input wire logic i_clk,
  output zone_pkg::apb_req_t o_apb,
  input wire logic [zone_pkg::DATA_W-1:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  logic [DATA_W-1:0] rd_data;
  logic rd_err;
  initial o_apb = '0;
  // Waits for ready; only the bench watchdog ends a stuck wait
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    do
      @(posedge i_clk);
    while (i_pready !== 1'b1);
    rd_data = i_prdata;
    rd_err = i_pslverr;
    o_apb <= '0;
  endtask : xfer
endmodule : zone_ctrl_model

// ---- test/tb_paging_panel.sv ----
/*
 Self-checking bench for the paging panel.
 Assumes short sim timing parameters and the zone controller model.
*/
`timescale 1ns/1ps
module tb_paging_panel;
  import zone_pkg::*;
  localparam logic [1:0] OFF = 2'b00, GRN = 2'b01, RED = 2'b10, ORG = 2'b11;
  logic clk, nrst, pready, pslverr, all_led, clr_led, voice, chime, fw_msg;
  logic [KEYS-1:0] keys;
  apb_req_t apb;
  logic [DATA_W-1:0] prdata;
  bicolour_t [ZONES-1:0] zled;
  bicolour_t pled;
  logic [GROUPS-1:0] gled;
  logic [ZONES-1:0] dash;
  int num_errors = 0;
  int check_count = 0;
  int n;
  paging_panel #(.BLINK_HALF_CYCLES(4), .CHIME_CYCLES(20), .FLASH_N(3))
    paging_panel_inst (.I_CLOCK(clk), .I_NRST(nrst), .I_APB(apb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_ZONE_KEY(keys[ZONES-1:0]), .I_GROUP_KEY_ONE(keys[KEY_GRP]),
    .I_GROUP_KEY_TWO(keys[KEY_GRP+1]), .I_ALL_KEY(keys[KEY_ALL]),
    .I_CLEAR_SELECTION_KEY(keys[KEY_CLR]), .I_PAGE_KEY(keys[KEY_PAGE]),
    .O_ZONE_LED(zled), .O_PAGE_LED(pled), .O_ALL_LED(all_led),
    .O_CLEAR_LED(clr_led), .O_GROUP_LED(gled), .O_VOICE_ON(voice),
    .O_CHIME_START(chime), .O_DISP_DASH(dash), .O_DISP_FW_MSG(fw_msg));
  zone_ctrl_model zone_ctrl_model_inst (.i_clk(clk), .o_apb(apb),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    check_count++;
    if (got !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    zone_ctrl_model_inst.xfer(1'b1, a, d);
    // Interrupt latch and page state land one edge after the write
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input logic err);
    zone_ctrl_model_inst.xfer(1'b0, a, '0);
    chk(zone_ctrl_model_inst.rd_data, e);
    chk(32'(zone_ctrl_model_inst.rd_err), 32'(err));
  endtask : rd
  // Holds the key, optionally checks its own led mid-press
  task automatic press(input int k, input logic led_exp);
    keys[k] <= 1'b1;
    repeat (8) @(posedge clk);
    if (k == KEY_ALL) chk(32'(all_led), 32'(led_exp));
    if (k == KEY_CLR) chk(32'(clr_led), 32'(led_exp));
    keys[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
  function automatic logic [1:0] probe(input int s);
    if (s < ZONES) return zled[s];
    if (s == ZONES) return pled;
    return {1'b0, gled[s-ZONES-1]};
  endfunction : probe
  task automatic count(input int s, input logic [1:0] e);
    n = 0;
    repeat (16)
    begin
      @(posedge clk);
      if (probe(s) === e) n++;
    end
  endtask : count
  task automatic t_reset();
    rd(ADDR_CTRL, '0, 1'b0);
    rd(ADDR_SEL, '0, 1'b0);
    rd(8'h40, '0, 1'b1);
    chk(32'(pled), 32'(RED));
    chk(32'(dash), 32'hFFFF);
  endtask : t_reset
  task automatic t_select();
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_ZONE_EN, 32'h00FF);
    chk(32'(dash), 32'hFF00);
    press(0, 1'b0);
    rd(ADDR_SEL, 32'h1, 1'b0);
    chk(32'(zled[0]), 32'(GRN));
    press(0, 1'b0);
    rd(ADDR_SEL, 32'h0, 1'b0);
    chk(32'(zled[0]), 32'(OFF));
    keys[8] <= 1'b1;
    count(8, GRN);
    keys[8] <= 1'b0;
    chk(32'(n > 0 && n < 16), 32'h1);
    repeat (24) @(posedge clk);
    chk(32'(zled[8]), 32'(OFF));
    press(KEY_ALL, 1'b1);
    rd(ADDR_SEL, 32'h00FF, 1'b0);
    press(KEY_CLR, 1'b1);
    rd(ADDR_SEL, 32'h0, 1'b0);
    rd(ADDR_KEYEV, 32'h000C0101, 1'b0);
    wr(ADDR_KEYEV, 32'h000C0101);
    rd(ADDR_KEYEV, 32'h0, 1'b0);
  endtask : t_select
  task automatic t_hold_intr();
    press(0, 1'b0);
    wr(ADDR_HOLD, 32'h3);
    count(0, ORG);
    chk(32'(n > 0 && n < 16), 32'h1);
    count(1, RED);
    chk(32'(n), 32'd16);
    wr(ADDR_HOLD, 32'h0);
    chk(32'({zled[1], zled[0]}), 32'({OFF, GRN}));
    wr(ADDR_INTR, 32'h1);
    count(0, ORG);
    chk(32'(n), 32'd16);
    press(0, 1'b0);
    chk(32'(zled[0]), 32'(GRN));
    rd(ADDR_INTR, 32'h0, 1'b0);
  endtask : t_hold_intr
  task automatic t_page();
    wr(ADDR_CTRL, 32'h5);
    keys[KEY_PAGE] <= 1'b1;
    for (int i = 0; i < 20 && chime !== 1'b1; i++) @(posedge clk);
    chk(32'(chime), 32'h1);
    count(ZONES, ORG);
    chk(32'(n), 32'd16);
    press(1, 1'b0);
    chk(32'({voice, pled}), 32'({1'b1, GRN}));
    rd(ADDR_SEL, 32'h1, 1'b0);
    keys[KEY_PAGE] <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'({voice, pled}), 32'({1'b0, OFF}));
    wr(ADDR_CTRL, 32'h41);
    chk(32'(gled[0]), 32'h0);
    keys[KEY_PAGE] <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({voice, chime, pled}), 32'({2'b10, GRN}));
    keys[KEY_PAGE] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : t_page
  task automatic t_group_fw();
    wr(ADDR_GROUP1, 32'h0030);
    wr(ADDR_CTRL, 32'h51);
    count(ZONES + 1, GRN);
    chk(32'(n), 32'd16);
    count(ZONES + 2, GRN);
    chk(32'(n > 0 && n < 16), 32'h1);
    press(KEY_GRP, 1'b0);
    rd(ADDR_SEL, 32'h31, 1'b0);
    wr(ADDR_CTRL, 32'h2);
    chk(32'({fw_msg, pled}), 32'({1'b1, ORG}));
    wr(ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk(32'({fw_msg, pled}), 32'({1'b0, RED}));
  endtask : t_group_fw
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Run takes about 400 cycles
  initial
  begin
    repeat (6000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial
  begin
    nrst = 1'b0;
    keys = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_select();
    t_hold_intr();
    t_page();
    t_group_fw();
    stop_test();
  end
endmodule : tb_paging_panel
bind paging_panel paging_panel_properties paging_panel_properties_inst (
  .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_APB(I_APB), .O_PSLVERR(O_PSLVERR),
  .I_ALL_KEY(I_ALL_KEY), .I_CLEAR_SELECTION_KEY(I_CLEAR_SELECTION_KEY),
  .I_PAGE_KEY(I_PAGE_KEY), .O_PAGE_LED(O_PAGE_LED), .O_ALL_LED(O_ALL_LED),
  .O_CLEAR_LED(O_CLEAR_LED), .O_VOICE_ON(O_VOICE_ON),
  .O_CHIME_START(O_CHIME_START), .O_DISP_FW_MSG(O_DISP_FW_MSG));
